// >>> radio_port_regs.vh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a plain strobe register port
`ifndef RADIO_PORT_REGS_VH
`define RADIO_PORT_REGS_VH

`define ADDR_W           4
`define ADDR_CTRL        4'h0
`define ADDR_FAULT_MASK  4'h1
`define ADDR_FAULT_CAUSE 4'h2
`define ADDR_STATUS      4'h3
`define ADDR_BAUD        4'h4

`define CTRL_ACK_EN      0
`define CTRL_RST         8'h00
`define FAULT_MASK_RST   8'h00

`define STAT_DRAINED     7
`define STAT_CTS_N       6
`define STAT_SLEEP       5
`define STAT_ACK_WAIT    4

`define CLK_HZ           100000000
`define BAUD_HZ          115200
`define BAUD_DIV_RST     16'h0364

`define FIFO_W           8
`define FIFO_D           16

`endif

// >>> byte_fifo.v
// flip-flop fifo with valid/ready on both sides
// assumes one clock; full and empty are registered flags
module byte_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          clk_sys,
	input  wire          reset,
	input  wire [W-1:0]  in_data,
	input  wire          in_valid,
	output wire          in_ready,
	output wire [W-1:0]  out_data,
	output wire          out_valid,
	input  wire          out_ready,
	output wire [AW:0]   level
);
	reg [W-1:0] mem_r [0:D-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0]   cnt_r;
	reg          full_r;
	reg          empty_r;
	wire         push = in_valid & ~full_r;
	wire         pop  = out_ready & ~empty_r;
	reg [AW:0]   cnt_nxt;

	assign in_ready  = ~full_r;
	assign out_valid = ~empty_r;
	assign out_data  = mem_r[rp_r];
	assign level     = cnt_r;

	always @* begin
		cnt_nxt = cnt_r;
		if (push & ~pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop & ~push)
			cnt_nxt = cnt_r - 1'b1;
	end

	always @(posedge clk_sys) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			wp_r    <= {AW{1'b0}};
			rp_r    <= {AW{1'b0}};
			cnt_r   <= {(AW+1){1'b0}};
			full_r  <= 1'b0;
			empty_r <= 1'b1;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r   <= cnt_nxt;
			full_r  <= (cnt_nxt == D[AW:0]);
			empty_r <= (cnt_nxt == {(AW+1){1'b0}});
		end
	end
endmodule // byte_fifo

// >>> serial_byte_link.v
// 8n1 serial receiver and transmitter, bit time set by a divisor
// assumes rx_in is already synchronised to clk_sys
module serial_byte_link (
	input  wire        clk_sys,
	input  wire        reset,
	input  wire [15:0] div,
	input  wire        rx_in,
	output reg  [7:0]  rx_data,
	output reg         rx_valid,
	input  wire [7:0]  tx_data,
	input  wire        tx_load,
	output wire        tx_busy,
	output reg         tx_line
);
	reg [15:0] rx_cnt_r;
	reg [3:0]  rx_bit_r;
	reg        rx_act_r;
	reg [7:0]  rx_sh_r;
	reg [15:0] tx_cnt_r;
	reg [3:0]  tx_bit_r;
	reg [8:0]  tx_sh_r;

	assign tx_busy = (tx_bit_r != 4'h0);

	always @(posedge clk_sys) begin
		if (reset) begin
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_act_r <= 1'b0;
			rx_sh_r  <= 8'h00;
			rx_data  <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_act_r) begin
				if (!rx_in) begin
					// first sample lands mid start bit
					rx_act_r <= 1'b1;
					rx_cnt_r <= {1'b0, div[15:1]};
					rx_bit_r <= 4'h0;
				end
			end else if (rx_cnt_r != 16'h0000) begin
				rx_cnt_r <= rx_cnt_r - 16'h0001;
			end else begin
				rx_cnt_r <= div;
				rx_bit_r <= rx_bit_r + 4'h1;
				if (rx_bit_r == 4'h0) begin
					if (rx_in)
						rx_act_r <= 1'b0;
				end else if (rx_bit_r == 4'h9) begin
					rx_act_r <= 1'b0;
					rx_data  <= rx_sh_r;
					rx_valid <= rx_in;
				end else begin
					rx_sh_r <= {rx_in, rx_sh_r[7:1]};
				end
			end
		end
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			tx_cnt_r <= 16'h0000;
			tx_bit_r <= 4'h0;
			tx_sh_r  <= 9'h1FF;
			tx_line  <= 1'b1;
		end else if (tx_bit_r == 4'h0) begin
			tx_line <= 1'b1;
			if (tx_load) begin
				tx_sh_r  <= {1'b1, tx_data};
				tx_line  <= 1'b0;
				tx_cnt_r <= div;
				tx_bit_r <= 4'hA;
			end
		end else if (tx_cnt_r != 16'h0000) begin
			tx_cnt_r <= tx_cnt_r - 16'h0001;
		end else begin
			tx_cnt_r <= div;
			tx_bit_r <= tx_bit_r - 4'h1;
			tx_line  <= (tx_bit_r == 4'h1) ? 1'b1 : tx_sh_r[0];
			tx_sh_r  <= {1'b1, tx_sh_r[8:1]};
		end
	end
endmodule // serial_byte_link

// >>> radio_module_host_port.v
// host-facing port of a hopping radio module: serial link, flow control,
// fault alert, restore sequence, amp gates and activity light
// assumes the modem core sits on the user ports and shares clk_sys
// Function
// - reset pin held low resets the block; it runs again once high
// - bytes taken as commands while select low, payload while high
// - sleep pin low puts the block idle; high resumes operation
// - four high pulses then a long high restore factory defaults
// - air payload and command replies share one serial output
// - reply marker low for command replies, high for air data
// - receive amp gate high while receiving
// - transmit amp gate high while transmitting
// - fault alert rises for fault causes enabled in the mask
// - reading the fault cause register drops the fault alert
// - queue-drained high when the serial input buffer is empty
// - with ack on, drained waits for remote ack or retry fault
// - activity light flashes with lengths telling the state
`include "radio_port_regs.vh"
module radio_module_host_port #(
	parameter RESTORE_HOLD_CYC = 32'd50000000,
	parameter BLINK_W          = 24
) (
	input  wire                clk_sys,
	input  wire                reset,
	input  wire [`ADDR_W-1:0]  reg_addr,
	input  wire [7:0]          reg_wdata,
	input  wire                reg_wr,
	input  wire                reg_rd,
	output reg  [7:0]          reg_rdata,
	input  wire                reset_pin_n,
	input  wire                serial_in,
	input  wire                cmd_select_n,
	input  wire                power_down_n,
	input  wire                defaults_restore_in,
	output wire                serial_out,
	output reg                 cts_n,
	output reg                 reply_marker_n,
	output reg                 tx_queue_drained,
	output reg                 fault_alert_out,
	output reg                 rx_amp_gate,
	output reg                 tx_amp_gate,
	output reg                 activity_light,
	output reg                 restore_defaults,
	output reg  [7:0]          cmd_byte,
	output reg                 cmd_valid,
	output reg  [7:0]          pay_data,
	output reg                 pay_valid,
	input  wire                pay_ready,
	input  wire [7:0]          resp_data,
	input  wire                resp_valid,
	output reg                 resp_take,
	input  wire [7:0]          air_data,
	input  wire                air_valid,
	output reg                 air_take,
	input  wire                radio_rx_busy,
	input  wire                radio_tx_busy,
	input  wire                ack_seen,
	input  wire                retry_fault,
	input  wire [7:0]          fault_evt
);
	localparam NPIN = 5;
	localparam LS_IDLE = 2'b00;
	localparam LS_HIGH = 2'b01;
	localparam LS_LOW  = 2'b10;
	localparam LS_DONE = 2'b11;

	wire [NPIN-1:0] pin_raw;
	wire [NPIN-1:0] pin_rst;
	reg  [NPIN-1:0] s1_r;
	reg  [NPIN-1:0] s2_r;
	reg  [NPIN-1:0] s3_r;
	reg  [NPIN-1:0] pin_r;
	reg  [7:0]      ctrl_r;
	reg  [7:0]      mask_r;
	reg  [7:0]      cause_r;
	reg  [15:0]     baud_r;
	reg             ack_wait_r;
	reg  [1:0]      rs_state_r;
	reg  [2:0]      rs_cnt_r;
	reg  [31:0]     rs_hold_r;
	reg  [BLINK_W-1:0] blink_r;
	wire            rx_s;
	wire            sel_n_s;
	wire            pd_n_s;
	wire            rst_n_s;
	wire            rs_s;
	wire            blk_rst;
	wire            sleep;
	wire [7:0]      rx_byte;
	wire            rx_stb;
	wire            tx_busy;
	wire            tx_load;
	wire [7:0]      tx_byte;
	wire            fifo_in_ready;
	wire [7:0]      fifo_out;
	wire            fifo_out_valid;
	wire            fifo_pop;
	wire [4:0]      fifo_level;
	wire            pay_fire;
	wire            rd_cause;
	wire            push_pay;

	assign pin_raw = {defaults_restore_in, reset_pin_n, power_down_n,
		cmd_select_n, serial_in};
	assign pin_rst = 5'h0F;

	// three stages; a change is taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
			always @(posedge clk_sys) begin
				if (reset) begin
					s1_r[gi]  <= pin_rst[gi];
					s2_r[gi]  <= pin_rst[gi];
					s3_r[gi]  <= pin_rst[gi];
					pin_r[gi] <= pin_rst[gi];
				end else begin
					s1_r[gi] <= pin_raw[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi])
						pin_r[gi] <= s3_r[gi];
				end
			end
		end
	endgenerate

	assign rx_s    = pin_r[0];
	assign sel_n_s = pin_r[1];
	assign pd_n_s  = pin_r[2];
	assign rst_n_s = pin_r[3];
	assign rs_s    = pin_r[4];
	assign blk_rst = reset | ~rst_n_s;
	assign sleep   = ~pd_n_s;

	// link held in reset while asleep, so no byte is half-taken
	serial_byte_link u_link (
		.clk_sys  (clk_sys),
		.reset    (blk_rst | sleep),
		.div      (baud_r),
		.rx_in    (rx_s),
		.rx_data  (rx_byte),
		.rx_valid (rx_stb),
		.tx_data  (tx_byte),
		.tx_load  (tx_load),
		.tx_busy  (tx_busy),
		.tx_line  (serial_out)
	);

	// payload routed to the queue only while select is high
	assign push_pay = rx_stb & sel_n_s;

	byte_fifo #(
		.W  (`FIFO_W),
		.D  (`FIFO_D),
		.AW (4)
	) u_fifo (
		.clk_sys   (clk_sys),
		.reset     (blk_rst),
		.in_data   (rx_byte),
		.in_valid  (push_pay),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.level     (fifo_level)
	);

	assign pay_fire = pay_valid & pay_ready;
	assign fifo_pop = fifo_out_valid & (~pay_valid | pay_fire) & ~sleep;

	always @(posedge clk_sys) begin
		if (blk_rst) begin
			cmd_byte  <= 8'h00;
			cmd_valid <= 1'b0;
			pay_data  <= 8'h00;
			pay_valid <= 1'b0;
		end else begin
			cmd_valid <= rx_stb & ~sel_n_s;
			if (rx_stb & ~sel_n_s)
				cmd_byte <= rx_byte;
			if (fifo_pop) begin
				pay_data  <= fifo_out;
				pay_valid <= 1'b1;
			end else if (pay_fire) begin
				pay_valid <= 1'b0;
			end
		end
	end

	// one fifo slot of margin covers the host's reaction to the flag
	always @(posedge clk_sys) begin
		if (blk_rst)
			cts_n <= 1'b1;
		else
			cts_n <= sleep | ~fifo_in_ready
				| (fifo_level >= 5'd15);
	end

	// replies win over air data; marker follows each loaded byte
	assign tx_load = ~tx_busy & ~sleep & ~resp_take & ~air_take
		& (resp_valid | air_valid);
	assign tx_byte = resp_valid ? resp_data : air_data;

	always @(posedge clk_sys) begin
		if (blk_rst) begin
			resp_take      <= 1'b0;
			air_take       <= 1'b0;
			reply_marker_n <= 1'b1;
		end else begin
			resp_take <= tx_load & resp_valid;
			air_take  <= tx_load & ~resp_valid;
			if (tx_load)
				reply_marker_n <= ~resp_valid;
		end
	end

	// ack wait: a new byte leaving beats an ack in the same cycle
	always @(posedge clk_sys) begin
		if (blk_rst)
			ack_wait_r <= 1'b0;
		else if (pay_fire & ctrl_r[`CTRL_ACK_EN])
			ack_wait_r <= 1'b1;
		else if (ack_seen | retry_fault | ~ctrl_r[`CTRL_ACK_EN])
			ack_wait_r <= 1'b0;
	end

	always @(posedge clk_sys) begin
		if (blk_rst)
			tx_queue_drained <= 1'b1;
		else
			tx_queue_drained <= (fifo_level == 5'd0) & ~pay_valid
				& ~push_pay & ~ack_wait_r;
	end

	always @(posedge clk_sys) begin
		if (blk_rst) begin
			rx_amp_gate <= 1'b0;
			tx_amp_gate <= 1'b0;
		end else begin
			rx_amp_gate <= radio_rx_busy & ~sleep;
			tx_amp_gate <= radio_tx_busy & ~sleep;
		end
	end

	// register port: writes steer, reads answer one cycle later
	assign rd_cause = reg_rd & (reg_addr == `ADDR_FAULT_CAUSE);

	always @(posedge clk_sys) begin
		if (blk_rst) begin
			ctrl_r <= `CTRL_RST;
			mask_r <= `FAULT_MASK_RST;
			baud_r <= `BAUD_DIV_RST;
		end else if (reg_wr) begin
			if (reg_addr == `ADDR_CTRL)
				ctrl_r <= reg_wdata;
			else if (reg_addr == `ADDR_FAULT_MASK)
				mask_r <= reg_wdata;
			else if (reg_addr == `ADDR_BAUD)
				baud_r <= {8'h00, reg_wdata};
		end
	end

	// baud reg holds the low byte only; reset value keeps 115200
	always @(posedge clk_sys) begin
		if (blk_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			if (reg_addr == `ADDR_CTRL)
				reg_rdata <= ctrl_r;
			else if (reg_addr == `ADDR_FAULT_MASK)
				reg_rdata <= mask_r;
			else if (reg_addr == `ADDR_FAULT_CAUSE)
				reg_rdata <= cause_r;
			else if (reg_addr == `ADDR_STATUS)
				reg_rdata <= {tx_queue_drained, cts_n, sleep,
					ack_wait_r, fifo_level[3:0]};
			else if (reg_addr == `ADDR_BAUD)
				reg_rdata <= baud_r[7:0];
			else
				reg_rdata <= 8'h00;
		end else
			reg_rdata <= 8'h00;
	end

	// sticky causes; an event in the read cycle survives the clear
	always @(posedge clk_sys) begin
		if (blk_rst)
			cause_r <= 8'h00;
		else if (rd_cause)
			cause_r <= fault_evt;
		else
			cause_r <= cause_r | fault_evt;
	end

	always @(posedge clk_sys) begin
		if (blk_rst)
			fault_alert_out <= 1'b0;
		else if (rd_cause)
			fault_alert_out <= |(fault_evt & mask_r);
		else
			fault_alert_out <= |((cause_r | fault_evt) & mask_r);
	end

	// restore: four high pulses, then a high held for the hold count
	always @(posedge clk_sys) begin
		if (blk_rst) begin
			rs_state_r       <= LS_IDLE;
			rs_cnt_r         <= 3'd0;
			rs_hold_r        <= 32'd0;
			restore_defaults <= 1'b0;
		end else begin
			restore_defaults <= 1'b0;
			case (rs_state_r)
			LS_IDLE: begin
				rs_cnt_r  <= 3'd0;
				rs_hold_r <= 32'd0;
				if (rs_s)
					rs_state_r <= LS_HIGH;
			end
			LS_HIGH: begin
				if (!rs_s) begin
					rs_state_r <= LS_LOW;
					rs_hold_r  <= 32'd0;
					if (rs_cnt_r != 3'd4)
						rs_cnt_r <= rs_cnt_r + 3'd1;
				end else if (rs_hold_r == RESTORE_HOLD_CYC - 32'd1) begin
					if (rs_cnt_r == 3'd4) begin
						restore_defaults <= 1'b1;
						rs_state_r       <= LS_DONE;
					end else begin
						rs_cnt_r  <= 3'd0;
						rs_hold_r <= 32'd0;
					end
				end else
					rs_hold_r <= rs_hold_r + 32'd1;
			end
			LS_LOW: begin
				if (rs_s) begin
					rs_state_r <= LS_HIGH;
					rs_hold_r  <= 32'd0;
				end
			end
			default: begin
				if (!rs_s)
					rs_state_r <= LS_IDLE;
			end
			endcase
		end
	end

	// flash length tells the state: off asleep, short idle, long busy
	always @(posedge clk_sys) begin
		if (blk_rst) begin
			blink_r        <= {BLINK_W{1'b0}};
			activity_light <= 1'b0;
		end else begin
			blink_r <= blink_r + 1'b1;
			if (sleep)
				activity_light <= 1'b0;
			else if (radio_tx_busy | radio_rx_busy)
				activity_light <= blink_r[BLINK_W-1];
			else
				activity_light <= &blink_r[BLINK_W-1:BLINK_W-3];
		end
	end
endmodule // radio_module_host_port

// >>> host_port_checker.sv
// pin-level assertions for the radio host port
// assumes sync reset and the sim hold count handed down by the bind
`include "radio_port_regs.vh"
module host_port_checker #(
	parameter RESTORE_HOLD_CYC = 32'd20
) (
	input wire logic               clk_sys,
	input wire logic               reset,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic               reset_pin_n,
	input wire logic               power_down_n,
	input wire logic               defaults_restore_in,
	input wire logic               serial_out,
	input wire logic               cts_n,
	input wire logic               reply_marker_n,
	input wire logic               tx_queue_drained,
	input wire logic               fault_alert_out,
	input wire logic               rx_amp_gate,
	input wire logic               tx_amp_gate,
	input wire logic               restore_defaults,
	input wire logic               resp_take,
	input wire logic               air_take,
	input wire logic               radio_rx_busy,
	input wire logic               radio_tx_busy,
	input wire logic [7:0]         fault_evt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] hi_cnt;
	// mask writes can raise the alert too, so they count as a cause
	wire         ev_any = (fault_evt != 8'h00) || reg_wr;
	// raw pin high time; the design sees it later through its sync flops
	always @(posedge clk_sys) begin
		if (reset || !defaults_restore_in)
			hi_cnt <= 32'd0;
		else
			hi_cnt <= hi_cnt + 32'd1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_pin_reset;
		(!reset_pin_n)[*8] |-> cts_n && tx_queue_drained && !fault_alert_out && serial_out;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset state wrong");
	property p_sleep;
		(!power_down_n)[*8] |-> cts_n && !rx_amp_gate && !tx_amp_gate;
	endproperty
	a_sleep: assert property (p_sleep) else $error("asleep but active");
	property p_rx_gate;
		rx_amp_gate |-> $past(radio_rx_busy);
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx gate without receive");
	property p_rx_on;
		(power_down_n && reset_pin_n)[*8] ##0 radio_rx_busy |=> rx_amp_gate;
	endproperty
	a_rx_on: assert property (p_rx_on) else $error("rx gate missing");
	property p_tx_gate;
		tx_amp_gate |-> $past(radio_tx_busy);
	endproperty
	a_tx_gate: assert property (p_tx_gate) else $error("tx gate without transmit");
	property p_alert_cause;
		$rose(fault_alert_out) |-> $past(ev_any) || $past(ev_any, 2);
	endproperty
	a_alert_cause: assert property (p_alert_cause) else $error("alert without cause");
	property p_alert_clear;
		(reg_rd && reg_addr == `ADDR_FAULT_CAUSE && !ev_any) ##1 !ev_any ##1 !ev_any |=> !fault_alert_out;
	endproperty
	a_alert_clear: assert property (p_alert_clear) else $error("alert kept after read");
	property p_marker_reply;
		resp_take |-> !reply_marker_n && !serial_out;
	endproperty
	a_marker_reply: assert property (p_marker_reply) else $error("reply start wrong");
	property p_marker_air;
		air_take |-> reply_marker_n && !serial_out;
	endproperty
	a_marker_air: assert property (p_marker_air) else $error("air start wrong");
	property p_restore;
		restore_defaults |-> hi_cnt >= RESTORE_HOLD_CYC;
	endproperty
	a_restore: assert property (p_restore) else $error("restore too early");
endmodule // host_port_checker

// >>> host_model.sv
// host microcontroller model: 8n1 bytes into the port and pin levels
// assumes the bench keeps bit_cyc equal to the written divisor plus one
module host_model (
	input  wire logic clk_sys,
	input  wire logic cts_n,
	output logic      serial_in,
	output logic      cmd_select_n,
	output logic      reset_pin_n,
	output logic      power_down_n,
	output logic      defaults_restore_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_cyc = 8;
	initial begin
		serial_in = 1'b1;
		cmd_select_n = 1'b1;
		reset_pin_n = 1'b1;
		power_down_n = 1'b1;
		defaults_restore_in = 1'b0;
	end
	// gives up rather than overrun the port when clear-to-send stays high
	task send_byte(input logic [7:0] b, input logic sel);
		logic [9:0] f;
		int         n;
		f = {1'b1, b, 1'b0};
		n = 0;
		while (cts_n !== 1'b0 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		if (cts_n === 1'b0) begin
			cmd_select_n <= sel;
			for (int i = 0; i < 10; i++) begin
				serial_in <= f[i];
				repeat (bit_cyc) @(posedge clk_sys);
			end
		end
	endtask
	task restore(input int pulses, input int hold);
		for (int i = 0; i < pulses; i++) begin
			defaults_restore_in <= 1'b1;
			repeat (6) @(posedge clk_sys);
			defaults_restore_in <= 1'b0;
			repeat (6) @(posedge clk_sys);
		end
		defaults_restore_in <= 1'b1;
		repeat (hold) @(posedge clk_sys);
		defaults_restore_in <= 1'b0;
	endtask
endmodule // host_model

// >>> tb_radio_module_host_port.sv
// bench for the host port: register tasks, host model, modem-side stubs
// assumes short restore and blink counts for simulation
`include "radio_port_regs.vh"
module tb_radio_module_host_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk_sys, reset, reg_wr, reg_rd, pay_ready, resp_valid, air_valid;
	logic              radio_rx_busy, radio_tx_busy, ack_seen, retry_fault;
	logic [`ADDR_W-1:0] reg_addr;
	logic [7:0]        reg_wdata, resp_data, air_data, fault_evt;
	wire  [7:0]        reg_rdata, cmd_byte, pay_data;
	wire               serial_in, cmd_select_n, reset_pin_n, power_down_n, defaults_restore_in;
	wire               serial_out, cts_n, reply_marker_n, tx_queue_drained, fault_alert_out;
	wire               rx_amp_gate, tx_amp_gate, activity_light, restore_defaults;
	wire               cmd_valid, pay_valid, resp_take, air_take;
	int                err_total, checks_done, n_restore, lit_cnt, lit0, lit_busy;
	logic [7:0]        cmd_q[$], pay_q[$];
	radio_module_host_port #(.RESTORE_HOLD_CYC(32'd20), .BLINK_W(4)) i_dut (
		.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reset_pin_n,
		.serial_in, .cmd_select_n, .power_down_n, .defaults_restore_in, .serial_out, .cts_n,
		.reply_marker_n, .tx_queue_drained, .fault_alert_out, .rx_amp_gate, .tx_amp_gate,
		.activity_light, .restore_defaults, .cmd_byte, .cmd_valid, .pay_data, .pay_valid,
		.pay_ready, .resp_data, .resp_valid, .resp_take, .air_data, .air_valid, .air_take,
		.radio_rx_busy, .radio_tx_busy, .ack_seen, .retry_fault, .fault_evt);
	host_model i_host (.clk_sys, .cts_n, .serial_in, .cmd_select_n, .reset_pin_n, .power_down_n,
		.defaults_restore_in);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1)
			cmd_q.push_back(cmd_byte);
		if (pay_valid === 1'b1 && pay_ready === 1'b1)
			pay_q.push_back(pay_data);
		if (restore_defaults === 1'b1)
			n_restore++;
		if (activity_light === 1'b1)
			lit_cnt++;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rdchk(input logic [`ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// reply or air byte out; decoded mid-bit from the take edge
	task out_byte(input logic air, input logic [7:0] d);
		logic [7:0] b;
		int         n;
		@(posedge clk_sys);
		air_data <= d;
		resp_data <= d;
		air_valid <= air;
		resp_valid <= !air;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (resp_take !== 1'b1 && air_take !== 1'b1 && n < 50);
		resp_valid <= 1'b0;
		air_valid <= 1'b0;
		chk({7'h00, reply_marker_n}, {7'h00, air});
		repeat (4) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (8) @(posedge clk_sys);
			#1 b[i] = serial_out;
		end
		chk(b, d);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		err_total++;
		$display("FAIL %0t watchdog expired", $time);
		end_sim;
	end
	initial begin
		{reset, reg_wr, reg_rd, pay_ready, resp_valid, air_valid} = 6'h20;
		{radio_rx_busy, radio_tx_busy, ack_seen, retry_fault} = 4'h0;
		{reg_addr, reg_wdata, resp_data, air_data, fault_evt} = '0;
		{err_total, checks_done, n_restore, lit_cnt} = '0;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk({7'h00, cts_n}, 8'h00);
		chk({7'h00, tx_queue_drained}, 8'h01);
		rdchk(`ADDR_CTRL, `CTRL_RST);
		rdchk(`ADDR_FAULT_MASK, `FAULT_MASK_RST);
		rdchk(4'hF, 8'h00);
		wr(`ADDR_BAUD, 8'h07);
		rdchk(`ADDR_BAUD, 8'h07);
		$display("reset and registers done");
		i_host.send_byte(8'hA5, 1'b0);
		for (int i = 0; i < 16; i++)
			i_host.send_byte(8'h30 + 8'(i), 1'b1);
		repeat (20) @(posedge clk_sys);
		#1 chk(8'(cmd_q.size()), 8'h01);
		chk(cmd_q[0], 8'hA5);
		chk({6'h00, cts_n, tx_queue_drained}, 8'h02);
		rdchk(`ADDR_STATUS, 8'h4F);
		pay_ready <= 1'b1;
		repeat (40) @(posedge clk_sys);
		#1 chk(8'(pay_q.size()), 8'h10);
		for (int i = 0; i < 16; i++)
			chk(pay_q[i], 8'h30 + 8'(i));
		rdchk(`ADDR_STATUS, 8'h80);
		$display("queue fill and drain done");
		wr(`ADDR_CTRL, 8'h01);
		for (int k = 0; k < 2; k++) begin
			i_host.send_byte(8'h44, 1'b1);
			repeat (10) @(posedge clk_sys);
			#1 chk({7'h00, tx_queue_drained}, 8'h00);
			ack_seen <= (k == 0);
			retry_fault <= (k == 1);
			@(posedge clk_sys);
			{ack_seen, retry_fault} <= 2'b00;
			repeat (3) @(posedge clk_sys);
			#1 chk({7'h00, tx_queue_drained}, 8'h01);
		end
		$display("ack wait done");
		wr(`ADDR_FAULT_MASK, 8'h01);
		for (int k = 2; k > 0; k--) begin
			@(posedge clk_sys);
			fault_evt <= 8'(k);
			@(posedge clk_sys);
			fault_evt <= 8'h00;
			repeat (4) @(posedge clk_sys);
			#1 chk({7'h00, fault_alert_out}, 8'(2 - k));
		end
		rdchk(`ADDR_FAULT_CAUSE, 8'h03);
		repeat (3) @(posedge clk_sys);
		#1 chk({7'h00, fault_alert_out}, 8'h00);
		rdchk(`ADDR_FAULT_CAUSE, 8'h00);
		$display("fault alert done");
		out_byte(1'b0, 8'h5A);
		out_byte(1'b1, 8'hC3);
		$display("serial out done");
		for (int k = 0; k < 4; k++) begin
			{radio_tx_busy, radio_rx_busy} <= 2'(k);
			repeat (3) @(posedge clk_sys);
			#1 chk({6'h00, tx_amp_gate, rx_amp_gate}, 8'(k));
		end
		lit0 = lit_cnt;
		repeat (32) @(posedge clk_sys);
		#1 lit_busy = lit_cnt - lit0;
		i_host.power_down_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		#1 chk({5'h00, cts_n, tx_amp_gate, rx_amp_gate}, 8'h04);
		lit0 = lit_cnt;
		repeat (16) @(posedge clk_sys);
		#1 chk(8'(lit_cnt - lit0), 8'h00);
		i_host.power_down_n <= 1'b1;
		repeat (10) @(posedge clk_sys);
		#1 chk({5'h00, cts_n, tx_amp_gate, rx_amp_gate}, 8'h03);
		{radio_tx_busy, radio_rx_busy} <= 2'b00;
		repeat (4) @(posedge clk_sys);
		#1 lit0 = lit_cnt;
		repeat (32) @(posedge clk_sys);
		#1 chk({7'h00, (lit_cnt > lit0) && (lit_cnt - lit0 < lit_busy)}, 8'h01);
		$display("amp gates and sleep done");
		wr(`ADDR_FAULT_MASK, 8'hFF);
		i_host.reset_pin_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		#1 chk({6'h00, cts_n, tx_queue_drained}, 8'h03);
		i_host.reset_pin_n <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rdchk(`ADDR_FAULT_MASK, 8'h00);
		$display("reset pin done");
		i_host.restore(3, 40);
		repeat (10) @(posedge clk_sys);
		#1 chk(8'(n_restore), 8'h00);
		i_host.restore(4, 40);
		repeat (10) @(posedge clk_sys);
		#1 chk(8'(n_restore), 8'h01);
		$display("restore sequence done");
		end_sim;
	end
endmodule // tb_radio_module_host_port
bind radio_module_host_port host_port_checker #(.RESTORE_HOLD_CYC(RESTORE_HOLD_CYC)) i_chk (
	.clk_sys, .reset, .reg_addr, .reg_wr, .reg_rd, .reset_pin_n, .power_down_n, .defaults_restore_in,
	.serial_out, .cts_n, .reply_marker_n, .tx_queue_drained, .fault_alert_out, .rx_amp_gate,
	.tx_amp_gate, .restore_defaults, .resp_take, .air_take, .radio_rx_busy, .radio_tx_busy, .fault_evt);
